/* hw/ppdh_defs.svh */
// Constants for the pin power-down hold block: timing figures and option defaults.
// Assumes a 125 MHz system clock; included by bare name.
`ifndef PPDH_DEFS_SVH
`define PPDH_DEFS_SVH
`define PPDH_CLK_PERIOD_NS 8
`define PPDH_RECOVER_NS 1000
// Cycles of wake latency outside the recovery count: pin slack, two sync flops, state and pad registers.
`define PPDH_WAKE_LAT_CYC 5
`define PPDH_RECOVER_CYC (((`PPDH_RECOVER_NS) / (`PPDH_CLK_PERIOD_NS)) - (`PPDH_WAKE_LAT_CYC))
`define PPDH_SETUP_FAST_NS 15
`define PPDH_SETUP_SLOW_NS 20
`define PPDH_HOLD_FAST_NS 25
`define PPDH_HOLD_SLOW_NS 30
`define PPDH_SLEEP_PINS 2
`define PPDH_DATA_W 8
`endif

/* hw/ppdh_pkg.sv */
// Types for the pin power-down hold block.
// Assumes nothing beyond the constants header.
package ppdh_pkg;
    typedef enum logic [1:0] {
        PPDH_RUN,
        PPDH_SLEEP,
        PPDH_RECOVER
    } ppdh_state_e;
endpackage : ppdh_pkg

/* hw/ppdh_sync.sv */
// Two-flop synchroniser for a bus of pin levels.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/1ns
module ppdh_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : ppdh_sync

/* hw/ppdh_top.sv */
// Power-down hold logic: freezes outputs and state while a configured sleep request pin is high.
// Assumes pins are asynchronous, the core logic is supplied outside via core_* ports.
`timescale 1ns/1ns
`include "ppdh_defs.svh"
module ppdh_top #(
    parameter int DATA_W = `PPDH_DATA_W,
    parameter int NPINS = `PPDH_SLEEP_PINS,
    parameter int RECOVER_CYC = `PPDH_RECOVER_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [NPINS-1:0] sleep_option,
    input wire logic [NPINS-1:0] sleep_request_pin,
    input wire logic [DATA_W-1:0] pin_in,
    input wire logic [DATA_W-1:0] core_out,
    input wire logic [DATA_W-1:0] core_oe_n,
    output logic [DATA_W-1:0] pin_hold_r,
    output logic [NPINS-1:0] sleep_pin_array_r,
    output logic [DATA_W-1:0] pad_out_r,
    output logic [DATA_W-1:0] pad_oe_n_r,
    output logic core_run_r,
    output logic asleep_r
);
    import ppdh_pkg::*;

    // Refuse sizes the logic cannot serve; the wake check needs a delay range of at most 999 cycles.
    if (DATA_W < 1 || NPINS < 1 || RECOVER_CYC < 1 || RECOVER_CYC > 998) begin : g_bad_param
        $error("ppdh_top: bad parameters");
    end

    // The recovery counter runs from 0 to RECOVER_CYC, holding RECOVER_CYC for the first cycle back in run.
    localparam int CW = $clog2(RECOVER_CYC + 1);
    // Cycles from the last sleep cycle until core_run_r is seen high.
    localparam int WAKE_MAX = RECOVER_CYC + 1;

    // Inputs and pads may move only in a cycle that stays in run.
    function automatic logic stays_running(input ppdh_state_e cur, input ppdh_state_e nxt);
        return cur == PPDH_RUN && nxt == PPDH_RUN;
    endfunction : stays_running

    logic [NPINS-1:0] opt_r;
    logic [NPINS-1:0] sleep_s;
    logic [DATA_W-1:0] pin_s;
    logic sleep_req;
    ppdh_state_e state_r;
    ppdh_state_e state_nxt;
    logic [CW-1:0] cnt_r;

    // Both pin groups are asynchronous to clk, so they pass two flops before any logic.
    // The sleep path therefore answers three cycles after the pin moves: two flops, then the state register.
    ppdh_sync #(.W(NPINS)) u_sync_sleep (
        .clk(clk),
        .rst_n(rst_n),
        .d(sleep_request_pin),
        .q(sleep_s)
    );
    ppdh_sync #(.W(DATA_W)) u_sync_pin (
        .clk(clk),
        .rst_n(rst_n),
        .d(pin_in),
        .q(pin_s)
    );

    // Option straps are captured while reset is held, clocked.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            opt_r <= sleep_option;
        end
    end

    // option gating: only configured pins can request sleep.
    // two pins: any configured pin requests power-down.
    assign sleep_req = |(sleep_s & opt_r);

    // sleep entry: state machine follows the request.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PPDH_RUN: begin
                if (sleep_req) begin
                    state_nxt = PPDH_SLEEP;
                end
            end
            PPDH_SLEEP: begin
                if (!sleep_req) begin
                    state_nxt = PPDH_RECOVER;
                end
            end
            PPDH_RECOVER: begin
                if (sleep_req) begin
                    state_nxt = PPDH_SLEEP;
                end else if (cnt_r == CW'(RECOVER_CYC - 1)) begin
                    state_nxt = PPDH_RUN;
                end
            end
            default: state_nxt = PPDH_RUN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= PPDH_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // recovery count: with the wake latency, wake completes exactly at the 1000 ns limit.
    always_ff @(posedge clk) begin
        if (!rst_n || state_r != PPDH_RECOVER) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // input blocking: sampled pins update only when running.
    // hold latches: held value kept while asleep or recovering.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_hold_r <= '0;
        end else if (stays_running(state_r, state_nxt)) begin
            pin_hold_r <= pin_s;
        end
    end

    // array input: sleep pin in use never feeds the logic array.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sleep_pin_array_r <= '0;
        end else begin
            sleep_pin_array_r <= sleep_s & ~opt_r;
        end
    end

    // output hold: pads and enables freeze when leaving run.
    // float kept: held enable keeps a floating pad floating.
    // glitch-free resume: pads update again only after recovery.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pad_out_r <= '0;
            pad_oe_n_r <= '1;
        end else if (stays_running(state_r, state_nxt)) begin
            pad_out_r <= core_out;
            pad_oe_n_r <= core_oe_n;
        end
    end

    // state hold: core registers advance only when running.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            core_run_r <= 1'b0;
            asleep_r <= 1'b0;
        end else begin
            core_run_r <= (state_nxt == PPDH_RUN);
            asleep_r <= (state_nxt == PPDH_SLEEP);
        end
    end

    a_hold_pads: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == PPDH_SLEEP && $past(state_r) == PPDH_SLEEP) |-> $stable(pad_out_r))
        else $error("pad data changed while asleep");
    a_float_kept: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == PPDH_SLEEP && $past(state_r) == PPDH_SLEEP) |-> $stable(pad_oe_n_r))
        else $error("pad enable changed while asleep");
    a_inputs_blocked: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r != PPDH_RUN) |=> (state_r == PPDH_RUN || $stable(pin_hold_r)))
        else $error("input sampled while asleep");
    a_sleep_entry: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == PPDH_RUN && sleep_req) |=> asleep_r)
        else $error("sleep request not honoured");
    a_option_gate: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == PPDH_RUN && (sleep_s & opt_r) == '0) |=> !asleep_r)
        else $error("slept without option");
    a_array_block: assert property (@(posedge clk) disable iff (!rst_n)
        ((sleep_s & opt_r) != '0) |=> ((sleep_pin_array_r & opt_r) == '0))
        else $error("sleep pin reached array");
    // Leaving sleep, the core runs again or a renewed request sleeps within WAKE_MAX cycles, one more than the recovery count.
    a_wake_time: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == PPDH_SLEEP && !sleep_req) |-> ##[1:WAKE_MAX] (core_run_r || asleep_r))
        else $error("recovery too long");
    a_run_flag: assert property (@(posedge clk) disable iff (!rst_n)
        core_run_r |-> (state_r == PPDH_RUN && !asleep_r))
        else $error("run flag inconsistent");
    a_hold_latch: assert property (@(posedge clk) disable iff (!rst_n)
        (asleep_r ##1 asleep_r) |-> $stable(pin_hold_r))
        else $error("hold latch lost value");

    // The entry cycle itself must not move the pads either.
    a_float_entry: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == PPDH_RUN && state_nxt == PPDH_SLEEP) |=> ($stable(pad_oe_n_r) && $stable(pad_out_r)))
        else $error("pads moved on sleep entry");
    a_sleep_stay: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == PPDH_SLEEP && sleep_req) |=> asleep_r)
        else $error("left sleep while requested");
    a_recover_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == PPDH_RECOVER) |=> ($stable(pad_out_r) && $stable(pin_hold_r)))
        else $error("pads moved during recovery");
    // A pad changes only after a cycle spent in run, so no glitch leaks out of sleep or recovery.
    a_resume_clean: assert property (@(posedge clk) disable iff (!rst_n)
        !$stable(pad_out_r) |-> ($past(state_r) == PPDH_RUN))
        else $error("pad changed outside run");

    // either pin: each configured pin alone puts the device to sleep.
    for (genvar gi = 0; gi < NPINS; gi++) begin : g_pin_chk
        a_pin_request: assert property (@(posedge clk) disable iff (!rst_n)
            (state_r == PPDH_RUN && sleep_s[gi] && opt_r[gi]) |=> asleep_r)
            else $error("configured pin did not request sleep");
    end
endmodule : ppdh_top

/* verification/ppdh_ctrl_model.sv */
// Behavioural model of the external controller on the sleep request and I/O pins.
// Assumes the bench sets its controls just after a rising edge of clk.
`timescale 1ns/1ns
module ppdh_ctrl_model #(
    // Cycles of sleep pin high before inputs may wander; covers the longer hold time at 8 ns.
    parameter int HOLD_CYC = 4
) (
    input wire logic clk,
    input wire logic [1:0] sleep_req,
    input wire logic dont_care,
    input wire logic [7:0] level,
    output logic [1:0] sleep_request_pin,
    output logic [7:0] pin_in
);
    initial begin
        sleep_request_pin = 2'h0;
        pin_in = 8'h00;
    end
    int high_cyc = 0;
    // set-up: levels follow the bench, which settles them well before any request.
    // hold window: inputs wander only once the sleep pin has been high long enough.
    always @(posedge clk) begin
        sleep_request_pin <= sleep_req;
        high_cyc <= (|sleep_request_pin) ? high_cyc + 1 : 0;
        // Once the hold time is over and dont_care is set, the lines carry a pattern that changes every cycle.
        pin_in <= (dont_care && high_cyc >= HOLD_CYC) ? ~pin_in : level;
    end
endmodule : ppdh_ctrl_model

/* verification/tb.sv */
// Self-checking bench for the pin power-down hold block.
// Assumes a short recovery count so a wake-up takes a few cycles.
`timescale 1ns/1ns
module tb;
    localparam int RC = 4;
    logic clk = 1'b0;
    logic rst_n, dc, run_r, sleep_r;
    logic [1:0] opt, req, spin, arr;
    logic [7:0] level, pin_in, cout, coe_n, hold, pout, poe_n;
    int num_errors = 0;
    int check_count = 0;
    int n;
    always #4 clk = ~clk;
    ppdh_ctrl_model ctrl_u (.clk(clk), .sleep_req(req), .dont_care(dc), .level(level),
        .sleep_request_pin(spin), .pin_in(pin_in));
    ppdh_top #(.RECOVER_CYC(RC)) dut_u (.clk(clk), .rst_n(rst_n), .sleep_option(opt),
        .sleep_request_pin(spin), .pin_in(pin_in), .core_out(cout), .core_oe_n(coe_n),
        .pin_hold_r(hold), .sleep_pin_array_r(arr), .pad_out_r(pout), .pad_oe_n_r(poe_n),
        .core_run_r(run_r), .asleep_r(sleep_r));
    task end_sim;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    task chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask : chk
    task cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : cyc
    task wait_sig(input bit on_run, input logic v, output int cnt);
        #1;
        for (cnt = 0; cnt < 300 && (on_run ? run_r : sleep_r) !== v; cnt++) cyc(1);
        if (cnt == 300) begin
            num_errors++;
            $display("MISMATCH t=%0t wait timed out", $time);
            end_sim();
        end
    endtask : wait_sig
    task t_run;
        @(posedge clk);
        cout <= 8'hA5;
        coe_n <= 8'h0F;
        level <= 8'h3C;
        cyc(5);
        chk(pout, 8'hA5, "run data");
        chk(poe_n, 8'h0F, "run enable");
        chk(hold, 8'h3C, "run pins");
    endtask : t_run
    task t_sleep;
        @(posedge clk);
        req <= 2'h1;
        wait_sig(1'b0, 1'b1, n);
        chk(8'(n), 8'h04, "sleep entry");
        chk({7'h00, run_r}, 8'h00, "core halted");
        @(posedge clk);
        cout <= 8'h5A;
        coe_n <= 8'hF0;
        level <= 8'hC3;
        dc <= 1'b1;
        cyc(10);
        chk(pout, 8'hA5, "data held");
        chk(poe_n, 8'h0F, "float held");
        chk(hold, 8'h3C, "pins held");
        chk({6'h00, arr}, 8'h00, "array input");
    endtask : t_sleep
    task t_wake;
        @(posedge clk);
        req <= 2'h0;
        dc <= 1'b0;
        wait_sig(1'b0, 1'b0, n);
        chk(8'(n), 8'h04, "sleep release");
        chk(pout, 8'hA5, "held in recovery");
        wait_sig(1'b1, 1'b1, n);
        chk(8'(n), 8'(RC), "recovery length");
        cyc(5);
        chk(pout, 8'h5A, "resumed data");
        chk(poe_n, 8'hF0, "resumed enable");
        chk(hold, 8'hC3, "resumed pins");
    endtask : t_wake
    task t_unconf;
        @(posedge clk);
        req <= 2'h2;
        cyc(8);
        chk({7'h00, sleep_r}, 8'h00, "no sleep");
        chk({6'h00, arr}, 8'h02, "ordinary pin");
        @(posedge clk);
        req <= 2'h0;
    endtask : t_unconf
    task t_two_pins;
        @(posedge clk);
        rst_n <= 1'b0;
        opt <= 2'h3;
        cyc(2);
        chk(poe_n, 8'hFF, "mid reset enable");
        chk({7'h00, run_r}, 8'h00, "mid reset halted");
        @(posedge clk);
        rst_n <= 1'b1;
        cyc(2);
        @(posedge clk);
        req <= 2'h2;
        wait_sig(1'b0, 1'b1, n);
        chk(8'(n), 8'h04, "second pin sleep");
        chk({6'h00, arr}, 8'h00, "second pin array");
        @(posedge clk);
        req <= 2'h0;
        wait_sig(1'b1, 1'b1, n);
        chk(8'(n), 8'(RC + 4), "second pin wake");
    endtask : t_two_pins
    initial begin
        rst_n = 1'b0;
        opt = 2'h1;
        req = 2'h0;
        dc = 1'b0;
        level = 8'h00;
        cout = 8'h00;
        coe_n = 8'hFF;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        cyc(2);
        chk(poe_n, 8'hFF, "reset enable");
        t_run();
        t_sleep();
        t_wake();
        t_unconf();
        t_two_pins();
        end_sim();
    end
endmodule : tb
